// ---- shared/serial_dac_params.svh ----
/*
 * Constants of the serial converter load control: widths, codes and sizes.
 * Assumes it is included by the package and by the design file.
 */
`ifndef SERIAL_DAC_PARAMS_SVH
`define SERIAL_DAC_PARAMS_SVH

// ----------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------
`define DAC_WORD_BITS 16
`define DAC_CNT_BITS 5
`define DAC_FULL_COUNT 5'h10
`define DAC_MSB_BITS 4
`define DAC_SEG_COUNT 15
`define DAC_LADDER_BITS 12

// ----------------------------------------------------------------------
// Codes, reset values and synchroniser depth
// ----------------------------------------------------------------------
`define DAC_MIDSCALE 16'h8000
`define DAC_SEG_RESET 15'h00ff
`define DAC_SYNC_STAGES 2

`endif

// ---- shared/serial_dac_pkg.sv ----
/*
 * Types of the serial converter load control.
 * Assumes serial_dac_params.svh sits on the include path.
 */
`include "serial_dac_params.svh"

package serial_dac_pkg;

    // ------------------------------------------------------------------
    // Whole state of the control block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`DAC_SYNC_STAGES-1:0] sclk_sy;
        logic [`DAC_SYNC_STAGES-1:0] frame_sy;
        logic [`DAC_SYNC_STAGES-1:0] sin_sy;
        logic [`DAC_SYNC_STAGES-1:0] load_sy;
        logic [`DAC_SYNC_STAGES-1:0] clear_sy;
        logic [`DAC_SYNC_STAGES-1:0] pd_sy;
        logic sclk_d;
        logic frame_d;
        logic load_d;
        logic [`DAC_WORD_BITS-1:0] shreg;
        logic [`DAC_CNT_BITS-1:0] bit_cnt;
        logic [`DAC_WORD_BITS-1:0] in_reg;
        logic [`DAC_WORD_BITS-1:0] dac_reg;
        logic [`DAC_WORD_BITS-1:0] out_code;
        logic [`DAC_SEG_COUNT-1:0] seg;
        logic sdo_bit;
        logic sdo_oe;
        logic zero_hold;
        logic out_zero;
    } dac_state_s;

endpackage : serial_dac_pkg

// ---- logic/serial_dac_load_control.sv ----
/*
 * Digital front end of a 16-bit voltage-output converter: framed serial
 * input, input and converter registers, load modes, clear and power-down,
 * segment decode and serial chain output.
 * Assumes all link pins are asynchronous to clk_i and much slower than it
 * (shift clock at least eight clk_i periods), and an external pull-up on
 * the open-drain chain output.
 */
// Operation
// - Incoming serial data is held in a 16-bit shift register.
// - After reset, shift register and converter register hold midscale.
// - Codes are offset binary; midscale means zero volts.
// - Shift clock is honoured only while the frame select is low.
// - Serial input is sampled on each falling shift clock edge in a frame.
// - Frame end after sixteen bits copies the shift register into the input register.
// - Load falling while frame is high copies input to converter register.
// - Load low during shifting updates converter register at frame end.
// - Load high during shifting; later load falling edge updates it.
// - Top four bits drive 15 thermometer segments, low twelve the ladder.
// - Clear low zeroes output; zero stays until a converter register load with clear high.
// - Power-down overrides load and clear; registers stay writable.
// - Clear low, load low: both registers written, output stays zero.
// - Clear low, load high: input register only, output stays zero.
// - Clear high, load low: both registers written, output follows.
// - Clear high, load high: input register only, converter unchanged.
// - Chain output shows bits leaving the register, input delayed sixteen.
// - Frame with load high reads back converter register unchanged.
`include "serial_dac_params.svh"

module serial_dac_load_control (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic shift_clock_i,
    input wire logic frame_select_n_i,
    input wire logic serial_in_i,
    input wire logic load_output_n_i,
    input wire logic clear_output_n_i,
    input wire logic power_down_n_i,
    input wire logic serial_out_chain_i,
    output logic serial_out_chain_o,
    output logic serial_out_chain_oe_o,
    output logic [`DAC_WORD_BITS-1:0] input_code_o,
    output logic [`DAC_WORD_BITS-1:0] dac_code_o,
    output logic [`DAC_WORD_BITS-1:0] output_code_o,
    output logic [`DAC_SEG_COUNT-1:0] segment_o,
    output logic [`DAC_LADDER_BITS-1:0] ladder_o,
    output logic output_zero_o,
    output logic power_down_o
);

    // ------------------------------------------------------------------
    // State and edge detection
    // ------------------------------------------------------------------
    serial_dac_pkg::dac_state_s st_ff;
    serial_dac_pkg::dac_state_s nxt_st;

    logic sclk_fall;
    logic frame_fall;
    logic frame_rise;
    logic frame_low;
    logic load_fall;
    logic word_full;

    // Edges only look at the second synchroniser stage and its delayed copy
    assign sclk_fall = st_ff.sclk_d & ~st_ff.sclk_sy[1];
    assign frame_fall = st_ff.frame_d & ~st_ff.frame_sy[1];
    assign frame_rise = ~st_ff.frame_d & st_ff.frame_sy[1];
    assign frame_low = ~st_ff.frame_sy[1];
    assign load_fall = st_ff.load_d & ~st_ff.load_sy[1];
    assign word_full = (st_ff.bit_cnt == `DAC_FULL_COUNT);

    function automatic logic [`DAC_SEG_COUNT-1:0] thermo(
        input logic [`DAC_MSB_BITS-1:0] msbs
    );
        logic [`DAC_SEG_COUNT-1:0] t;
        t = '0;
        for (int i = 0; i < `DAC_SEG_COUNT; i++) begin
            t[i] = (msbs > i[`DAC_MSB_BITS-1:0]);
        end
        return t;
    endfunction : thermo

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic load_evt;
        load_evt = 1'b0;
        nxt_st = st_ff;
        nxt_st.sclk_sy = {st_ff.sclk_sy[0], shift_clock_i};
        nxt_st.frame_sy = {st_ff.frame_sy[0], frame_select_n_i};
        nxt_st.sin_sy = {st_ff.sin_sy[0], serial_in_i};
        nxt_st.load_sy = {st_ff.load_sy[0], load_output_n_i};
        nxt_st.clear_sy = {st_ff.clear_sy[0], clear_output_n_i};
        nxt_st.pd_sy = {st_ff.pd_sy[0], power_down_n_i};
        nxt_st.sclk_d = st_ff.sclk_sy[1];
        nxt_st.frame_d = st_ff.frame_sy[1];
        nxt_st.load_d = st_ff.load_sy[1];

        if (frame_fall) begin
            // Readback: the converter word leaves the chain pin MSB first
            nxt_st.shreg = st_ff.dac_reg;
            nxt_st.sdo_bit = st_ff.dac_reg[`DAC_WORD_BITS-1];
            nxt_st.bit_cnt = '0;
        end else if (frame_low && sclk_fall) begin
            nxt_st.shreg = {st_ff.shreg[`DAC_WORD_BITS-2:0], st_ff.sin_sy[1]};
            nxt_st.sdo_bit = st_ff.shreg[`DAC_WORD_BITS-2];
            if (!word_full) begin
                nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
            end
        end else if (!frame_low) begin
            nxt_st.bit_cnt = '0;
        end

        if (frame_rise) begin
            // A short frame leaves both registers alone
            if (word_full) begin
                nxt_st.in_reg = st_ff.shreg;
                if (!st_ff.load_sy[1]) begin
                    nxt_st.dac_reg = st_ff.shreg;
                    load_evt = 1'b1;
                end
            end
        end else if (load_fall && !frame_low) begin
            // Asynchronous update is refused while a frame is open
            nxt_st.dac_reg = st_ff.in_reg;
            load_evt = 1'b1;
        end

        // Clear low wins over a load in the same cycle
        if (!st_ff.clear_sy[1]) begin
            nxt_st.zero_hold = 1'b1;
        end else if (load_evt) begin
            nxt_st.zero_hold = 1'b0;
        end

        nxt_st.out_zero = ~st_ff.pd_sy[1] | nxt_st.zero_hold;
        // Zero volts is the midscale code in offset binary
        nxt_st.out_code = nxt_st.out_zero ? `DAC_MIDSCALE : nxt_st.dac_reg;
        nxt_st.seg = thermo(nxt_st.out_code[`DAC_WORD_BITS-1 -: `DAC_MSB_BITS]);
        // Pull-down released in power-down to save current
        nxt_st.sdo_oe = ~nxt_st.sdo_bit & st_ff.pd_sy[1];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff.sclk_sy <= '0;
            st_ff.frame_sy <= '1;
            st_ff.sin_sy <= '0;
            st_ff.load_sy <= '1;
            st_ff.clear_sy <= '1;
            st_ff.pd_sy <= '1;
            st_ff.sclk_d <= 1'b0;
            st_ff.frame_d <= 1'b1;
            st_ff.load_d <= 1'b1;
            st_ff.shreg <= `DAC_MIDSCALE;
            st_ff.bit_cnt <= '0;
            st_ff.in_reg <= `DAC_MIDSCALE;
            st_ff.dac_reg <= `DAC_MIDSCALE;
            st_ff.out_code <= `DAC_MIDSCALE;
            st_ff.seg <= `DAC_SEG_RESET;
            st_ff.sdo_bit <= 1'b1;
            st_ff.sdo_oe <= 1'b0;
            st_ff.zero_hold <= 1'b0;
            st_ff.out_zero <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open drain: the pin only ever pulls low
    assign serial_out_chain_o = 1'b0;
    assign serial_out_chain_oe_o = st_ff.sdo_oe;
    assign input_code_o = st_ff.in_reg;
    assign dac_code_o = st_ff.dac_reg;
    assign output_code_o = st_ff.out_code;
    assign segment_o = st_ff.seg;
    assign ladder_o = st_ff.out_code[`DAC_LADDER_BITS-1:0];
    assign output_zero_o = st_ff.out_zero;
    assign power_down_o = ~st_ff.pd_sy[1];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_frame_high_idle: assert property (st_ff.frame_sy[1] |=> st_ff.bit_cnt == '0)
        else $error("bit count moved outside a frame");

    a_shift_sample: assert property (frame_low && sclk_fall && !frame_fall
        |=> st_ff.shreg[0] == $past(st_ff.sin_sy[1]))
        else $error("serial bit not sampled on falling edge");

    a_auto_transfer: assert property (frame_rise && word_full
        |=> input_code_o == $past(st_ff.shreg))
        else $error("input register not loaded at frame end");

    a_sync_load: assert property (frame_rise && word_full && !st_ff.load_sy[1]
        |=> dac_code_o == $past(st_ff.shreg))
        else $error("synchronous load missed");

    a_async_load: assert property (load_fall && !frame_low && !frame_rise
        |=> dac_code_o == $past(input_code_o))
        else $error("asynchronous load missed");

    a_load_high_keep: assert property (frame_rise && st_ff.load_sy[1]
        |=> $stable(dac_code_o))
        else $error("converter register changed with load high");

    a_short_discard: assert property (frame_rise && !word_full
        |=> $stable(input_code_o) && $stable(dac_code_o))
        else $error("partial word was taken");

    // A load with clear high in the very next cycle may lift the hold again
    a_clear_zero: assert property (!st_ff.clear_sy[1]
        |=> output_zero_o && output_code_o == `DAC_MIDSCALE)
        else $error("clear did not zero the output");

    a_pd_zero: assert property (!st_ff.pd_sy[1] ##1 !st_ff.pd_sy[1]
        |-> output_zero_o && output_code_o == `DAC_MIDSCALE)
        else $error("power-down did not zero the output");

    a_segment_decode: assert property ($countones(segment_o)
        == output_code_o[`DAC_WORD_BITS-1 -: `DAC_MSB_BITS])
        else $error("segment count disagrees with code");

    a_chain_bit: assert property (frame_low && sclk_fall && !frame_fall && st_ff.pd_sy[1]
        |=> ##1 serial_out_chain_oe_o == ~$past(st_ff.shreg[`DAC_WORD_BITS-2], 2))
        else $error("chain output not the shifted bit");

    a_async_refused: assert property (load_fall && frame_low
        |=> $stable(dac_code_o))
        else $error("load edge inside a frame updated the converter");

    a_clear_hold: assert property (st_ff.zero_hold && !load_fall && !frame_rise
        |=> st_ff.zero_hold)
        else $error("zero hold dropped without a load");

    a_pd_writable: assert property (!st_ff.pd_sy[1] && frame_rise && word_full
        |=> input_code_o == $past(st_ff.shreg))
        else $error("input register not written in power-down");

    a_clear_priority: assert property (!st_ff.clear_sy[1] && frame_rise && word_full
        && !st_ff.load_sy[1]
        |=> dac_code_o == $past(st_ff.shreg) && output_code_o == `DAC_MIDSCALE)
        else $error("clear with load low not handled");

    a_clear_load_high: assert property (!st_ff.clear_sy[1] && frame_rise
        && st_ff.load_sy[1] |=> output_zero_o && $stable(dac_code_o))
        else $error("clear with load high not handled");

    a_output_follows: assert property (st_ff.pd_sy[1] && st_ff.clear_sy[1]
        && frame_rise && word_full && !st_ff.load_sy[1]
        |=> output_code_o == $past(st_ff.shreg))
        else $error("output did not follow the new word");

    a_dac_quiet: assert property (!frame_rise && !(load_fall && !frame_low)
        |=> $stable(dac_code_o))
        else $error("converter register changed without a load");

    a_zero_midscale: assert property (output_zero_o
        |-> output_code_o == `DAC_MIDSCALE)
        else $error("zeroed output not at midscale");

    a_code_follow: assert property (!output_zero_o
        |-> output_code_o == dac_code_o)
        else $error("output code differs from converter register");

    a_readback_start: assert property (frame_fall
        |=> st_ff.shreg == $past(dac_code_o) && st_ff.sdo_bit == $past(dac_code_o[15]))
        else $error("readback word not loaded at frame start");

    a_frame_ignore: assert property (!frame_low
        |=> $stable(st_ff.shreg))
        else $error("shift register moved outside a frame");

    a_count_saturate: assert property (word_full && frame_low
        |=> word_full)
        else $error("bit count left full inside a frame");

    a_chain_release: assert property (!st_ff.pd_sy[1]
        |=> !serial_out_chain_oe_o)
        else $error("chain pull-down active in power-down");

    a_input_kept: assert property (!frame_rise
        |=> $stable(input_code_o))
        else $error("input register changed outside a frame end");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    c_sync_load: cover property (frame_rise && word_full && !st_ff.load_sy[1]);
    c_pd_write: cover property (!st_ff.pd_sy[1] && frame_rise && word_full);
    c_async_load: cover property (load_fall && !frame_low);
    c_readback: cover property (frame_rise && word_full && st_ff.load_sy[1]);
    c_clear_release: cover property (!st_ff.clear_sy[1] ##1 st_ff.clear_sy[1] [*3]);

endmodule : serial_dac_load_control

// ---- verification/dac_host_model.sv ----
/*
 * Host side of the three-wire link: frames words onto the shift clock and
 * captures the chain pin before each falling edge.
 * Assumes the chain pin level is resolved with its pull-up by the bench.
 */
module dac_host_model (
    input wire logic clk_i,
    output logic sclk_o,
    output logic frame_n_o,
    output logic serial_in_o,
    input wire logic chain_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Four bench clocks per phase: 160 ns period, under the top serial rate
    localparam int HALF_CLKS = 4;

    initial begin
        sclk_o = 1'b0;
        frame_n_o = 1'b1;
        serial_in_o = 1'b0;
    end

    // All pins move by non-blocking assignment on the bench clock edge
    task automatic xfer(input logic [31:0] data, input int n, input logic framed,
                        output logic [31:0] rx);
        rx = '0;
        @(posedge clk_i);
        frame_n_o <= !framed;
        repeat (HALF_CLKS) @(posedge clk_i);
        for (int k = n - 1; k >= 0; k--) begin
            serial_in_o <= data[k];
            sclk_o <= 1'b1;
            repeat (HALF_CLKS) @(posedge clk_i);
            rx = {rx[30:0], chain_i};
            sclk_o <= 1'b0;
            repeat (HALF_CLKS) @(posedge clk_i);
        end
        @(posedge clk_i);
        frame_n_o <= 1'b1;
        // Released line must not keep showing the last bit
        serial_in_o <= !serial_in_o;
    endtask : xfer
endmodule : dac_host_model

// ---- verification/serial_dac_load_control_tb_top.sv ----
/*
 * Self-checking bench: host model drives the link, an integer model
 * predicts both code registers and every parallel output.
 * Assumes the parameter header is on the include path.
 */
`include "serial_dac_params.svh"
module serial_dac_load_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i, rst_b_i, sclk, frame_n, serial_in, load_n, clear_n, pd_n, chain_oe;
    logic [`DAC_WORD_BITS-1:0] in_code, dac_code, out_code;
    logic [`DAC_SEG_COUNT-1:0] seg;
    logic [`DAC_LADDER_BITS-1:0] ladder;
    logic out_zero, pd_o, chain_out;
    logic [31:0] rx, w;
    int bad_count = 0;
    int compares = 0;
    int in_m, dac_m, zero_m, ld_m, prev;
    // Pull-up holds the chain pin high whenever the pull-down lets go
    wire logic chain_pin = chain_oe ? chain_out : 1'b1;

    serial_dac_load_control dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .shift_clock_i(sclk), .frame_select_n_i(frame_n), .serial_in_i(serial_in),
        .load_output_n_i(load_n), .clear_output_n_i(clear_n), .power_down_n_i(pd_n),
        .serial_out_chain_i(chain_pin), .serial_out_chain_o(chain_out),
        .serial_out_chain_oe_o(chain_oe), .input_code_o(in_code), .dac_code_o(dac_code),
        .output_code_o(out_code), .segment_o(seg), .ladder_o(ladder),
        .output_zero_o(out_zero), .power_down_o(pd_o));
    dac_host_model host (.clk_i(clk_i), .sclk_o(sclk), .frame_n_o(frame_n), .serial_in_o(serial_in),
        .chain_i(chain_pin));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = !clk_i;
    end

    // ----------------------------------------------------------------
    // Checking and model
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_all();
        int o;
        int seg_m;
        repeat (10) @(posedge clk_i);
        #1;
        o = (zero_m != 0 || !pd_n) ? 32'h8000 : dac_m;
        seg_m = 0;
        for (int i = 0; i < 15; i++) if ((o >> 12) > i) seg_m |= 1 << i;
        check(in_code, in_m);
        check(dac_code, dac_m);
        check(out_code, o);
        check(seg, seg_m);
        check(ladder, o & 32'hfff);
        check(out_zero, zero_m != 0 || !pd_n);
        check(pd_o, !pd_n);
    endtask : check_all

    task automatic ctrl(input logic p, input logic c, input logic l);
        @(posedge clk_i);
        pd_n <= p;
        clear_n <= c;
        load_n <= l;
        if (!c) zero_m = 1;
        else if (ld_m != 0 && !l) zero_m = 0;
        if (ld_m != 0 && !l) dac_m = in_m;
        ld_m = l;
        check_all();
    endtask : ctrl

    task automatic frame(input logic [31:0] d, input int n, input logic framed);
        prev = dac_m;
        host.xfer(d, n, framed, rx);
        if (framed && n >= 16) begin
            in_m = d & 32'hffff;
            if (ld_m == 0) begin
                dac_m = in_m;
                if (clear_n) zero_m = 0;
            end
        end
        check_all();
    endtask : frame

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        load_n = 1'b1;
        clear_n = 1'b1;
        pd_n = 1'b1;
        in_m = 32'h8000;
        dac_m = 32'h8000;
        zero_m = 0;
        ld_m = 1;
        w = $urandom(14970);
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check_all();
        frame($urandom, 16, 1'b1);
        check(rx[15:0], prev);
        ctrl(1'b1, 1'b1, 1'b0);
        ctrl(1'b1, 1'b1, 1'b1);
        frame($urandom, 16, 1'b0);
        frame($urandom, 10, 1'b1);
        w = $urandom;
        frame(w, 32, 1'b1);
        check(rx[31:16], prev);
        check(rx[15:0], w[31:16]);
        // Load pulse inside a frame is refused; the word waits in the input register
        w = $urandom;
        fork
            host.xfer(w, 16, 1'b1, rx);
            begin
                repeat (40) @(posedge clk_i);
                load_n <= 1'b0;
                repeat (40) @(posedge clk_i);
                load_n <= 1'b1;
            end
        join
        in_m = w & 32'hffff;
        check_all();
        for (int c = 0; c < 8; c++) begin
            ctrl(c[2], c[1], c[0]);
            frame($urandom, 16, 1'b1);
        end
        ctrl(1'b1, 1'b0, 1'b1);
        ctrl(1'b1, 1'b1, 1'b1);
        ctrl(1'b1, 1'b1, 1'b0);
        // Mid-run reset must bring both registers back to midscale
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        in_m = 32'h8000;
        dac_m = 32'h8000;
        zero_m = 0;
        check_all();
        complete_run();
    end

    // Whole run is near 42 us; a hang is cut off well after that
    initial begin
        #1000000;
        bad_count++;
        complete_run();
    end
endmodule : serial_dac_load_control_tb_top
